// >>> design/ats_async_timer_update_sync.sv
// top: async status register, timer clock selection and update-busy crossing for timer two
// Behaviour
// - with the external clock enable set and async clocking chosen, the pin buffer is on.
// - the crystal oscillator runs only while the external clock enable bit is zero.
// - async select zero clocks the timer from the peripheral clock, one from the pin.
// - an async write to the counter sets its busy flag until the counter is loaded.
// - an async write to compare A sets its busy flag until compare A is transferred.
// - an async write to compare B sets its busy flag until compare B is transferred.
// - an async write to control A sets its busy flag until control A is transferred.
// - an async write to control B sets its busy flag until control B is transferred.
module ats_async_timer_update_sync (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic timer_clk,
  input wire ats_pkg::ats_bus_s bus,
  output logic [7:0] rdata,
  output logic osc_input_buffer_en,
  output logic crystal_osc_en,
  output logic timer_clk_from_pin,
  output ats_pkg::ats_values_s values,
  output logic [4:0] value_strobe
);
  logic ext_clock_input_enable_reg;
  logic async_clock_select_reg;
  logic [4:0] wr_hit;
  logic [4:0] busy;
  logic [4:0] pending;
  logic [7:0] sync_val_reg [5];
  logic [7:0] dst_val [5];
  logic [7:0] async_status_reg;

  // address decode used for write hits on the five values
  function automatic logic [2:0] value_index(input logic [7:0] addr);
    case (addr)
      ats_pkg::ATS_COUNTER_OFFSET: value_index = 3'(ats_pkg::ATS_IDX_COUNTER);
      ats_pkg::ATS_COMPARE_A_OFFSET: value_index = 3'(ats_pkg::ATS_IDX_COMPARE_A);
      ats_pkg::ATS_COMPARE_B_OFFSET: value_index = 3'(ats_pkg::ATS_IDX_COMPARE_B);
      ats_pkg::ATS_CONTROL_A_OFFSET: value_index = 3'(ats_pkg::ATS_IDX_CONTROL_A);
      ats_pkg::ATS_CONTROL_B_OFFSET: value_index = 3'(ats_pkg::ATS_IDX_CONTROL_B);
      default: value_index = 3'h7;
    endcase
  endfunction : value_index

  // writable mode bits of the status register; busy bits are read-only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_clock_input_enable_reg <= ats_pkg::ATS_STATUS_RESET[ats_pkg::ATS_EXT_CLK_BIT];
      async_clock_select_reg <= ats_pkg::ATS_STATUS_RESET[ats_pkg::ATS_ASYNC_SEL_BIT];
    end else if (bus.wr && bus.addr == ats_pkg::ATS_STATUS_OFFSET) begin
      ext_clock_input_enable_reg <= bus.wdata[ats_pkg::ATS_EXT_CLK_BIT];
      async_clock_select_reg <= bus.wdata[ats_pkg::ATS_ASYNC_SEL_BIT];
    end
  end

  // clock source steering; the mux itself sits in the clock tree outside this block
  assign osc_input_buffer_en = ext_clock_input_enable_reg && async_clock_select_reg;
  assign crystal_osc_en = !ext_clock_input_enable_reg;
  assign timer_clk_from_pin = async_clock_select_reg;

  // per value: async writes go through the handshake, sync writes load directly
  generate
    for (genvar i = 0; i < ats_pkg::ATS_NUM_VALUES; i++) begin : g_val
      logic hs_strobe;
      assign wr_hit[i] = bus.wr && value_index(bus.addr) == 3'(i);
      ats_handshake u_hs (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .timer_clk(timer_clk),
        .load(wr_hit[i] && async_clock_select_reg),
        .load_data(bus.wdata),
        .busy(busy[i]),
        .dst_strobe(hs_strobe),
        .dst_data(dst_val[i])
      );
      // synchronous mode copy, used while the timer runs on the peripheral clock
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          sync_val_reg[i] <= ats_pkg::ATS_VALUE_RESET;
        end else if (wr_hit[i] && !async_clock_select_reg) begin
          sync_val_reg[i] <= bus.wdata;
        end
      end
      // strobe is meaningful only in the domain currently clocking the timer
      assign value_strobe[i] = async_clock_select_reg ? hs_strobe : wr_hit[i];
      // busy bit i sits at position 4 - i; only async writes set it, and it stays visible
      // across a mode change so a crossing stalled by a stopped oscillator is not hidden
      assign pending[ats_pkg::ATS_NUM_VALUES - 1 - i] = busy[i];
    end
  endgenerate

  // values presented to the timer core, taken from whichever path is active
  assign values.counter_value = async_clock_select_reg ? dst_val[0] : sync_val_reg[0];
  assign values.compare_a_value = async_clock_select_reg ? dst_val[1] : sync_val_reg[1];
  assign values.compare_b_value = async_clock_select_reg ? dst_val[2] : sync_val_reg[2];
  assign values.control_a_value = async_clock_select_reg ? dst_val[3] : sync_val_reg[3];
  assign values.control_b_value = async_clock_select_reg ? dst_val[4] : sync_val_reg[4];

  // status read view; bit 7 reserved reads zero
  assign async_status_reg = {1'b0, ext_clock_input_enable_reg, async_clock_select_reg, pending};

  // read data register; writes while busy are dropped by the handshake (software must wait)
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else if (bus.rd && bus.addr == ats_pkg::ATS_STATUS_OFFSET) begin
      rdata <= async_status_reg;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : ats_async_timer_update_sync

// >>> design/ats_pkg.sv
// package: register map, field positions and types for the async timer update sync
package ats_pkg;
  // register map on the internal data bus
  localparam logic [7:0] ATS_STATUS_OFFSET = 8'hB6;
  localparam logic [7:0] ATS_COUNTER_OFFSET = 8'hB2;
  localparam logic [7:0] ATS_COMPARE_A_OFFSET = 8'hB3;
  localparam logic [7:0] ATS_COMPARE_B_OFFSET = 8'hB4;
  localparam logic [7:0] ATS_CONTROL_A_OFFSET = 8'hB0;
  localparam logic [7:0] ATS_CONTROL_B_OFFSET = 8'hB1;
  localparam logic [7:0] ATS_STATUS_RESET = 8'h00;
  localparam logic [7:0] ATS_VALUE_RESET = 8'h00;
  // field positions in the status register
  localparam int ATS_EXT_CLK_BIT = 6;
  localparam int ATS_ASYNC_SEL_BIT = 5;
  localparam int ATS_NUM_VALUES = 5;
  // synchroniser depth in flops
  localparam int ATS_SYNC_STAGES = 2;

  // index of each value; busy bit position equals 4 - index
  typedef enum logic [2:0] {
    ATS_IDX_COUNTER,
    ATS_IDX_COMPARE_A,
    ATS_IDX_COMPARE_B,
    ATS_IDX_CONTROL_A,
    ATS_IDX_CONTROL_B
  } ats_idx_e;

  // processor-side register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ats_bus_s;

  // the five timer values as seen in the timer domain
  typedef struct packed {
    logic [7:0] counter_value;
    logic [7:0] compare_a_value;
    logic [7:0] compare_b_value;
    logic [7:0] control_a_value;
    logic [7:0] control_b_value;
  } ats_values_s;
endpackage : ats_pkg

// >>> design/ats_handshake.sv
// module: one-value four-phase handshake from the processor clock to the timer clock
module ats_handshake (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic timer_clk,
  input wire logic load,
  input wire logic [7:0] load_data,
  output logic busy,
  output logic dst_strobe,
  output logic [7:0] dst_data
);
  logic req_reg;
  logic [7:0] hold_reg;
  logic [ats_pkg::ATS_SYNC_STAGES - 1:0] ack_sync_reg;
  logic [ats_pkg::ATS_SYNC_STAGES - 1:0] req_sync_reg;
  logic ack_reg;

  // temporary holding register; stable while req is high so the far side samples it safely
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_reg <= ats_pkg::ATS_VALUE_RESET;
    end else if (load && !busy) begin
      hold_reg <= load_data;
    end
  end

  // request stays up until the acknowledge returns, then drops; busy covers the whole loop
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_reg <= 1'b0;
    end else if (load && !busy) begin
      req_reg <= 1'b1;
    end else if (ack_sync_reg[ats_pkg::ATS_SYNC_STAGES - 1]) begin
      req_reg <= 1'b0;
    end
  end

  // acknowledge back into the processor domain
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_sync_reg <= '0;
    end else begin
      ack_sync_reg <= {ack_sync_reg[ats_pkg::ATS_SYNC_STAGES - 2:0], ack_reg};
    end
  end

  // busy until the request is down and the acknowledge seen down again
  assign busy = req_reg || ack_sync_reg[ats_pkg::ATS_SYNC_STAGES - 1];

  // timer-domain side: capture on the rising request, then acknowledge
  always_ff @(posedge timer_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_sync_reg <= '0;
      ack_reg <= 1'b0;
    end else begin
      req_sync_reg <= {req_sync_reg[ats_pkg::ATS_SYNC_STAGES - 2:0], req_reg};
      ack_reg <= req_sync_reg[ats_pkg::ATS_SYNC_STAGES - 1];
    end
  end

  // destination captures on the same timer clock edge at which the acknowledge rises
  assign dst_strobe = req_sync_reg[ats_pkg::ATS_SYNC_STAGES - 1] && !ack_reg;
  always_ff @(posedge timer_clk or negedge arst_n) begin
    if (!arst_n) begin
      dst_data <= ats_pkg::ATS_VALUE_RESET;
    end else if (dst_strobe) begin
      dst_data <= hold_reg;
    end
  end
endmodule : ats_handshake

// >>> testbench/ats_osc_model.sv
// partner: timer oscillator or external clock source feeding the async timer domain
module ats_osc_model #(
  parameter real HALF = 5.5
) (
  input wire logic run,
  output logic timer_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  // a stopped crystal gives no edges, so a pending crossing stalls as it would on silicon
  initial timer_clk = 1'b0;
  always begin
    #HALF;
    if (run === 1'b1) begin
      timer_clk = ~timer_clk;
    end
  end
endmodule : ats_osc_model

// >>> testbench/ats_async_timer_update_sync_assertions.sv
// checker: port-level assertions for the async timer update sync block
module ats_sva (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic timer_clk,
  input wire ats_pkg::ats_bus_s bus,
  input wire logic [7:0] rdata,
  input wire logic osc_input_buffer_en,
  input wire logic crystal_osc_en,
  input wire logic timer_clk_from_pin,
  input wire ats_pkg::ats_values_s values,
  input wire logic [4:0] value_strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  logic st_wr;
  // status writes decide every clock-selection output on the next cycle
  assign st_wr = bus.wr && bus.addr == ats_pkg::ATS_STATUS_OFFSET;
  // an async write must reach the timer domain within a bounded time
  property p_xfer(int i, logic [7:0] a);
    bus.wr && bus.addr == a && timer_clk_from_pin |-> ##[1:60] value_strobe[i];
  endproperty
  a_buffer_equation: assert property (
    osc_input_buffer_en == (!crystal_osc_en && timer_clk_from_pin))
    else $error("pin buffer enable disagrees with clock selection");
  a_select_write: assert property (st_wr |=> timer_clk_from_pin == $past(bus.wdata[5]))
    else $error("clock source does not follow async select");
  a_crystal_write: assert property (st_wr |=> crystal_osc_en == !$past(bus.wdata[6]))
    else $error("crystal enable does not follow ext clock bit");
  // in sync mode the strobe marks the very edge at which the counter copy loads
  a_sync_strobe: assert property (
    bus.wr && bus.addr == ats_pkg::ATS_COUNTER_OFFSET && !timer_clk_from_pin
    |-> value_strobe[0] ##1 values.counter_value == $past(bus.wdata))
    else $error("sync counter write not applied");
  a_counter_xfer: assert property (p_xfer(0, 8'hB2)) else $error("counter never loaded");
  a_cmpa_xfer: assert property (p_xfer(1, 8'hB3)) else $error("compare A never loaded");
  a_cmpb_xfer: assert property (p_xfer(2, 8'hB4)) else $error("compare B never loaded");
  a_ctla_xfer: assert property (p_xfer(3, 8'hB0)) else $error("control A never loaded");
  a_ctlb_xfer: assert property (p_xfer(4, 8'hB1)) else $error("control B never loaded");
  a_no_early: assert property (
    bus.wr && bus.addr == ats_pkg::ATS_COUNTER_OFFSET && timer_clk_from_pin
    |=> !value_strobe[0] [*2])
    else $error("counter loaded before synchronising");
  c_ext_clock: cover property (osc_input_buffer_en);
  c_ctlb_load: cover property (timer_clk_from_pin && value_strobe[4]);
  c_status_read: cover property (bus.rd && bus.addr == ats_pkg::ATS_STATUS_OFFSET);
  c_ext_xfer: cover property (osc_input_buffer_en && value_strobe[0]);
endmodule : ats_sva
bind ats_async_timer_update_sync ats_sva u_sva (.core_clk, .arst_n, .timer_clk, .bus, .rdata,
  .osc_input_buffer_en, .crystal_osc_en, .timer_clk_from_pin, .values, .value_strobe);

// >>> testbench/tb_async_timer_update_sync.sv
// testbench: random and corner-case register traffic for the async timer update sync block
module tb_async_timer_update_sync;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ADDRS [5] = '{8'hB2, 8'hB3, 8'hB4, 8'hB0, 8'hB1};
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic timer_clk, osc_input_buffer_en, crystal_osc_en, timer_clk_from_pin;
  ats_pkg::ats_bus_s bus = '0;
  ats_pkg::ats_values_s values;
  logic [7:0] rdata, got, d;
  logic [4:0] value_strobe;
  int errors = 0;
  int checked = 0;
  int n;
  int idx;
  logic [7:0] mode;
  always #2 core_clk = ~core_clk;
  ats_osc_model u_osc (.run(crystal_osc_en | osc_input_buffer_en), .timer_clk(timer_clk));
  ats_async_timer_update_sync u_dut (.core_clk, .arst_n, .timer_clk, .bus, .rdata,
    .osc_input_buffer_en, .crystal_osc_en, .timer_clk_from_pin, .values, .value_strobe);
  // expected status while value i is in flight: mode bits plus busy at bit 4 - i
  function automatic logic [7:0] busy_exp(int i);
    return mode | (8'h10 >> i);
  endfunction : busy_exp
  task automatic chk(string name, logic [7:0] exp, logic [7:0] seen);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge core_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk);
    bus <= '0;
  endtask : wr
  task automatic rd(logic [7:0] a);
    @(posedge core_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    bus <= '0;
    #1;
    got = rdata;
  endtask : rd
  // polling is bounded so a stuck busy flag ends the run instead of hanging it
  task automatic wait_idle();
    for (n = 0; n < 100; n++) begin
      rd(8'hB6);
      if (got[4:0] === 5'h00) break;
    end
    if (n == 100) begin
      errors++;
      $display("CHECK FAILED busy clear expected 00 seen %h", got[4:0]);
      print_verdict();
    end
  endtask : wait_idle
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    void'($urandom(32'h6f61f593));
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(8'hB6);
    chk("status reset", 8'h00, got);
    chk("crystal at reset", 8'h01, {7'h00, crystal_osc_en});
    rd(8'hB7);
    chk("unmapped read", 8'h00, got);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      wr(8'hB6, 8'(m << 5));
      rd(8'hB6);
      chk("status mode", 8'(m << 5), got);
      chk("pin buffer", {7'h00, m == 3}, {7'h00, osc_input_buffer_en});
      chk("crystal", {7'h00, m < 2}, {7'h00, crystal_osc_en});
      chk("clock from pin", {7'h00, m[0]}, {7'h00, timer_clk_from_pin});
    end
    $display("test modes done");
    wr(8'hB6, 8'h00); // back to sync mode with ext enable cleared before the sync value tests
    for (int i = 0; i < 5; i++) begin
      d = 8'($urandom);
      wr(ADDRS[i], d);
      rd(8'hB6);
      chk("no busy in sync", 8'h00, got);
      repeat (3) @(posedge core_clk);
      chk("sync value", d, values[39 - 8 * i -: 8]);
    end
    $display("test sync done");
    mode = 8'h20;
    wr(8'hB6, mode);
    for (int i = 0; i < 5; i++) begin // every value rewritten after the mode change
      d = 8'($urandom);
      wr(ADDRS[i], d);
      rd(8'hB6);
      chk("busy set", busy_exp(i), got);
      wait_idle();
      chk("value landed", d, values[39 - 8 * i -: 8]);
    end
    wr(8'hB1, 8'h5A);
    wr(8'hB1, 8'hA5);
    wait_idle();
    chk("write while busy dropped", 8'h5A, values.control_b_value);
    $display("test async done");
    // external clock: enable set in the same write that returns to synchronous, then async chosen
    wr(8'hB6, 8'h40);
    mode = 8'h60;
    wr(8'hB6, mode);
    for (int k = 0; k < 25; k++) begin // first five rewrite every value
      idx = (k < 5) ? k : $urandom_range(4, 0);
      d = 8'($urandom);
      wr(ADDRS[idx], d);
      rd(8'hB6);
      chk("ext busy", busy_exp(idx), got);
      wait_idle();
      chk("ext value landed", d, values[39 - 8 * idx -: 8]);
    end
    $display("test ext clock done");
    // reset while a crossing is in flight: both domains must drop it cleanly
    wr(8'hB2, 8'h3C);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(8'hB6);
    chk("status after reset", 8'h00, got);
    chk("crystal after reset", 8'h01, {7'h00, crystal_osc_en});
    chk("counter after reset", 8'h00, values.counter_value);
    $display("test mid reset done");
    print_verdict();
  end
endmodule : tb_async_timer_update_sync
